// *** verilog/lvd_pkg.sv ***
// Package: register map, field positions and reset values of the low-voltage detector control
package lvd_pkg;
  localparam logic [31:0] detector_control_offset         = 32'hfffff890;
  localparam logic [31:0] ram_valid_status_offset         = 32'hfffff892;
  localparam logic [31:0] detect_level_select_offset      = 32'hfffff894;
  localparam logic [31:0] emulation_pseudo_control_offset = 32'hfffff898;
  localparam logic [31:0] special_unlock_offset           = 32'hfffff89c;
  localparam logic [7:0]  special_unlock_key              = 8'ha5;

  localparam int detector_enable_pos   = 7;
  localparam int detector_mode_pos     = 1;
  localparam int low_supply_flag_pos   = 0;
  localparam int level_choice_pos      = 0;
  localparam int ram_invalid_pos       = 0;
  localparam int pseudo_detect_pos     = 2;

  localparam logic [7:0] detector_control_reset = 8'h00;
  localparam logic [7:0] level_select_reset     = 8'h00;
  localparam logic       ram_invalid_reset      = 1'b1;
  localparam logic       pseudo_detect_reset    = 1'b0;

  typedef struct packed {
    logic watchdog_reset;
    logic ram_access_reset;
    logic clock_monitor_reset;
    logic other_reset;
  } reset_events_t;

  typedef struct packed {
    logic irq;
    logic reset_req;
    logic level_choice;
  } detector_out_t;
endpackage

// *** verilog/low_voltage_detect_control.sv ***
// Low-voltage detector control, level select and RAM validity flag with Avalon-MM slave
`timescale 1ns/1ns

// Summary of operation
// RULE1: Level bit 0 drives comparator threshold select
// RULE2: Level register byte access; upper bits zero
// RULE3: RAM status written only via unlock sequence
// RULE4: Flag set by low supply, software, resets
// RULE5: Flag cleared only by protected zero write
// RULE6: Flag at bit 0; 1 means invalid
// RULE7: Detection raises interrupt or reset by mode
// RULE8: Software reset-mode start order, 0.2 ms wait; the testbench waits 4 clock cycles
// RULE9: Mode set locks control and level writes
// RULE10: Software interrupt-mode start order
// RULE11: Enable cleared stops interrupts and resets
// RULE12: Retention comparator low sets the flag
// RULE13: Pseudo register acts only in emulation
// RULE14: Pseudo detect one sets the flag
// RULE15: Pseudo detect high blocks flag clearing
// RULE16: Debugger halt, set, clear, resume order
// RULE17: Control bits: enable 7, mode 1, flag 0
// RULE18: Flag reads 1 only when enabled and low
// RULE19: Comparator inputs pass two flip-flops
// RULE20: Outputs follow synchronized flag per mode
module low_voltage_detect_control (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [31:0]            avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_readdatavalid,
  output logic                        avs_waitrequest,
  output logic      [1:0]             avs_response,
  input  wire logic                   supply_below_level,
  input  wire logic                   supply_below_retention,
  input  wire logic                   emulation_mode,
  input  wire lvd_pkg::reset_events_t reset_events,
  output lvd_pkg::detector_out_t      detector_out
);

  logic [1:0] lvl_sync_reg;
  logic [1:0] ret_sync_reg;
  logic       low_sync;
  logic       ret_sync;
  logic       enable_reg;
  logic       mode_reg;
  logic       level_reg;
  logic       ram_invalid_reg;
  logic       pseudo_reg;
  logic       pseudo_prev_reg;
  logic       unlock_reg;
  logic       lock_reg;
  logic       ack_reg;
  logic       irq_reg;
  logic       rstreq_reg;
  logic [7:0] rdata_next;
  logic       req;
  logic       wr_ok;
  logic       low_flag;
  logic       sel_ctrl;
  logic       sel_ram;
  logic       sel_lvl;
  logic       sel_emu;
  logic       sel_key;
  logic       mapped;
  logic [7:0] wbyte;

  // Two-stage synchronisers for comparator outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lvl_sync_reg <= 2'h0;
      ret_sync_reg <= 2'h3;
    end else begin
      lvl_sync_reg <= {lvl_sync_reg[0], supply_below_level};       // [RULE19]
      ret_sync_reg <= {ret_sync_reg[0], supply_below_retention};   // [RULE19]
    end
  end
  assign low_sync = lvl_sync_reg[1];
  assign ret_sync = ret_sync_reg[1];

  assign low_flag = enable_reg & low_sync;                         // [RULE18]

  // Address decode; every register occupies byte lane 0 of its word
  assign sel_ctrl = (avs_address == lvd_pkg::detector_control_offset);
  assign sel_ram  = (avs_address == lvd_pkg::ram_valid_status_offset);
  assign sel_lvl  = (avs_address == lvd_pkg::detect_level_select_offset);
  assign sel_emu  = (avs_address == lvd_pkg::emulation_pseudo_control_offset);
  assign sel_key  = (avs_address == lvd_pkg::special_unlock_offset);
  assign mapped   = sel_ctrl | sel_ram | sel_lvl | sel_emu | sel_key;
  assign wbyte    = avs_writedata[7:0];

  // One wait cycle, then accept on the second edge
  assign req             = (avs_read | avs_write) & ~ack_reg;
  assign avs_waitrequest = req;
  assign wr_ok           = avs_write & ~req & avs_byteenable[0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // Unlock key arms only the next write; any other write disarms it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      unlock_reg <= 1'b0;
    end else if (wr_ok & sel_key) begin
      unlock_reg <= (wbyte == lvd_pkg::special_unlock_key);
    end else if (avs_write & ~req) begin
      unlock_reg <= 1'b0;
    end
  end

  // Detector control and lock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enable_reg <= lvd_pkg::detector_control_reset[lvd_pkg::detector_enable_pos];
      mode_reg   <= lvd_pkg::detector_control_reset[lvd_pkg::detector_mode_pos];
      lock_reg   <= 1'b0;
    end else if (reset_events.other_reset) begin
      enable_reg <= lvd_pkg::detector_control_reset[lvd_pkg::detector_enable_pos];
      mode_reg   <= lvd_pkg::detector_control_reset[lvd_pkg::detector_mode_pos];
      lock_reg   <= 1'b0;                                          // [RULE9]
    end else if (wr_ok & sel_ctrl & unlock_reg & ~lock_reg) begin  // [RULE9]
      enable_reg <= wbyte[lvd_pkg::detector_enable_pos];           // [RULE11] [RULE17]
      mode_reg   <= wbyte[lvd_pkg::detector_mode_pos];             // [RULE17]
      lock_reg   <= wbyte[lvd_pkg::detector_mode_pos];             // [RULE9]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level_reg <= lvd_pkg::level_select_reset[lvd_pkg::level_choice_pos];
    end else if (reset_events.other_reset) begin
      level_reg <= lvd_pkg::level_select_reset[lvd_pkg::level_choice_pos];
    end else if (wr_ok & sel_lvl & ~lock_reg & (avs_byteenable == 4'h1)) begin  // [RULE2] [RULE9]
      level_reg <= wbyte[lvd_pkg::level_choice_pos];                          // [RULE1]
    end
  end

  // Pseudo detect register, meaningful only in emulation
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pseudo_reg      <= lvd_pkg::pseudo_detect_reset;
      pseudo_prev_reg <= lvd_pkg::pseudo_detect_reset;
    end else begin
      if (wr_ok & sel_emu) begin
        pseudo_reg <= wbyte[lvd_pkg::pseudo_detect_pos];
      end
      pseudo_prev_reg <= pseudo_reg & emulation_mode;
    end
  end

  // RAM invalid flag: every set source wins over a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ram_invalid_reg <= lvd_pkg::ram_invalid_reset;
    end else if (low_flag | ret_sync                               // [RULE4] [RULE12]
                 | reset_events.watchdog_reset | reset_events.ram_access_reset
                 | reset_events.clock_monitor_reset                // [RULE4]
                 | (emulation_mode & pseudo_reg & ~pseudo_prev_reg)) begin  // [RULE13] [RULE14]
      ram_invalid_reg <= 1'b1;
    end else if (wr_ok & sel_ram & unlock_reg) begin               // [RULE3]
      if (wbyte[lvd_pkg::ram_invalid_pos]) begin
        ram_invalid_reg <= 1'b1;                                   // [RULE4]
      end else if (~(emulation_mode & pseudo_reg)) begin           // [RULE15]
        ram_invalid_reg <= 1'b0;                                   // [RULE5]
      end
    end
  end

  // Interrupt and reset request outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_reg    <= 1'b0;
      rstreq_reg <= 1'b0;
    end else begin
      irq_reg    <= low_flag & ~mode_reg;                          // [RULE7] [RULE11] [RULE20]
      rstreq_reg <= low_flag & mode_reg;                           // [RULE7] [RULE11] [RULE20]
    end
  end
  assign detector_out.irq          = irq_reg;
  assign detector_out.reset_req    = rstreq_reg;
  assign detector_out.level_choice = level_reg;                    // [RULE1]

  // Read mux
  always_comb begin
    rdata_next = 8'h00;
    if (sel_ctrl) begin
      rdata_next[lvd_pkg::detector_enable_pos] = enable_reg;       // [RULE17]
      rdata_next[lvd_pkg::detector_mode_pos]   = mode_reg;
      rdata_next[lvd_pkg::low_supply_flag_pos] = low_flag;         // [RULE18]
    end else if (sel_ram) begin
      rdata_next[lvd_pkg::ram_invalid_pos] = ram_invalid_reg;      // [RULE6]
    end else if (sel_lvl) begin
      rdata_next[lvd_pkg::level_choice_pos] = level_reg;           // [RULE2]
    end else if (sel_emu) begin
      rdata_next[lvd_pkg::pseudo_detect_pos] = pseudo_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      avs_readdata      <= 32'h00000000;
      avs_readdatavalid <= 1'b0;
      avs_response      <= 2'h0;
    end else begin
      avs_readdatavalid <= 1'b0;
      if (avs_read & ~ack_reg) begin
        avs_readdata <= {24'h000000, rdata_next};
        avs_response <= mapped ? 2'h0 : 2'h2;
      end
    end
  end

endmodule

// *** verification/lvd_sva.sv ***
// Checker: bus timing and detector output relations at the block ports
`timescale 1ns/1ns
module lvd_sva (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic                   avs_waitrequest,
  input wire logic                   avs_readdatavalid,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   supply_below_level,
  input wire lvd_pkg::reset_events_t reset_events,
  input wire lvd_pkg::detector_out_t detector_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence req_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence level_quiet;
    !supply_below_level [*3];
  endsequence
  first_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state in first request cycle");
  one_wait_a: assert property (req_open |=> !avs_waitrequest)
    else $error("request not answered in second cycle");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait state without request");
  no_rdv_a: assert property (!avs_readdatavalid)
    else $error("read data valid pulsed");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  one_request_a: assert property (!(detector_out.irq && detector_out.reset_req))
    else $error("interrupt and reset requested together");
  irq_quiet_a: assert property (level_quiet |=> !detector_out.irq)
    else $error("interrupt with supply above level");
  rst_quiet_a: assert property (level_quiet |=> !detector_out.reset_req)
    else $error("reset request with supply above level");
  irq_cause_a: assert property (detector_out.irq |-> $past(supply_below_level, 3))
    else $error("interrupt without synchronized low supply");
  level_hold_a: assert property (!avs_write && !reset_events.other_reset |=> $stable(detector_out.level_choice))
    else $error("level select changed without write");
endmodule

// *** verification/low_voltage_detect_control_tb.sv ***
// Testbench: register access and detector scenarios
`timescale 1ns/1ns
module low_voltage_detect_control_tb;
  logic                   clk_sys, rst, avs_read, avs_write, avs_readdatavalid, avs_waitrequest;
  logic                   supply_below_level, supply_below_retention, emulation_mode;
  logic [31:0]            avs_address, avs_writedata, avs_readdata;
  logic [3:0]             avs_byteenable;
  logic [1:0]             avs_response;
  lvd_pkg::reset_events_t reset_events;
  lvd_pkg::detector_out_t detector_out;
  int                     n_errors = 0, compares = 0;
  localparam logic [31:0] ctl = lvd_pkg::detector_control_offset;
  localparam logic [31:0] ram = lvd_pkg::ram_valid_status_offset;
  localparam logic [31:0] lvl = lvd_pkg::detect_level_select_offset;
  localparam logic [31:0] emu = lvd_pkg::emulation_pseudo_control_offset;

  low_voltage_detect_control i_low_voltage_detect_control (.clk_sys, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_readdatavalid, .avs_waitrequest,
    .avs_response, .supply_below_level, .supply_below_retention, .emulation_mode, .reset_events,
    .detector_out);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, d, input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [3:0] be = 4'h1);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic pw(input logic [31:0] a, d);
    wr(lvd_pkg::special_unlock_offset, {24'h0, lvd_pkg::special_unlock_key});
    wr(a, d);
  endtask

  task automatic rd(input logic [31:0] a, exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h1, q);
    chk(q, exp);
  endtask

  task automatic wait_out(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    rst = 1'b1;
    {avs_read, avs_write, supply_below_level, supply_below_retention, emulation_mode} = 5'h0;
    avs_address = 32'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    reset_events = 4'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ram, 32'h1);
    rd(ctl, 32'h0);
    wr(lvl, 32'hff);
    rd(lvl, 32'h1);
    #1 chk(detector_out.level_choice, 32'h1);
    wr(lvl, 32'h0, 4'h3);
    rd(lvl, 32'h1);
    wr(lvl, 32'h0);
    rd(32'h0, 32'h0);
    chk(avs_response, 32'h2);
    wr(ram, 32'h0);
    rd(ram, 32'h1);
    pw(ram, 32'h0);
    rd(ram, 32'h0);
    pw(ram, 32'h1);
    rd(ram, 32'h1);
    // Clock-monitor, RAM-access and watchdog events in turn
    for (int i = 1; i < 4; i++) begin
      pw(ram, 32'h0);
      rd(ram, 32'h0);
      reset_events <= 4'h1 << i;
      @(posedge clk_sys);
      reset_events <= 4'h0;
      rd(ram, 32'h1);
    end
    pw(ram, 32'h0);
    supply_below_retention <= 1'b1;
    repeat (4) @(posedge clk_sys);
    supply_below_retention <= 1'b0;
    wait_out(4);
    rd(ram, 32'h1);
    pw(ram, 32'h0);
    wr(emu, 32'h4);
    rd(ram, 32'h0);
    wr(emu, 32'h0);
    emulation_mode <= 1'b1;
    wr(emu, 32'h4);
    rd(ram, 32'h1);
    pw(ram, 32'h0);
    rd(ram, 32'h1);
    wr(emu, 32'h0);
    pw(ram, 32'h0);
    rd(ram, 32'h0);
    emulation_mode <= 1'b0;
    // Interrupt use: level, enable, wait, confirm supply above level
    wr(lvl, 32'h0);
    pw(ctl, 32'h80);
    wait_out(4);
    rd(ctl, 32'h80);
    supply_below_level <= 1'b1;
    wait_out(5);
    chk(detector_out, 32'h4);
    rd(ctl, 32'h81);
    pw(ctl, 32'h0);
    wait_out(4);
    chk(detector_out, 32'h0);
    rd(ctl, 32'h0);
    // Reset use: level, enable, wait, confirm, then mode
    supply_below_level <= 1'b0;
    wr(lvl, 32'h1);
    pw(ctl, 32'h80);
    wait_out(4);
    rd(ctl, 32'h80);
    pw(ctl, 32'h82);
    supply_below_level <= 1'b1;
    wait_out(5);
    chk(detector_out, 32'h3);
    pw(ctl, 32'h0);
    wr(lvl, 32'h0);
    rd(ctl, 32'h83);
    rd(lvl, 32'h1);
    reset_events <= 4'h1;
    @(posedge clk_sys);
    reset_events <= 4'h0;
    rd(ctl, 32'h0);
    rd(lvl, 32'h0);
    give_verdict();
  end

  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end
endmodule

bind low_voltage_detect_control lvd_sva i_lvd_sva (.clk_sys, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdatavalid, .avs_readdata, .supply_below_level, .reset_events, .detector_out);
